// File: rtl/sk_pkg.sv
// Search key command unit shared constants and types
package sk_pkg;
  // Command codes
  localparam logic [7:0] SK_CMD_EQ_ST = 8'h29;
  localparam logic [7:0] SK_CMD_EQ_MT = 8'hA9;
  localparam logic [7:0] SK_CMD_HI_ST = 8'h49;
  localparam logic [7:0] SK_CMD_EH_ST = 8'h69;
  localparam logic [7:0] SK_CMD_EH_MT = 8'hE9;
  // Status byte bit positions (bit 7 is the first bit on the channel)
  localparam int SK_ST_SM = 6;
  localparam int SK_ST_CE = 3;
  localparam int SK_ST_DE = 2;
  localparam int SK_ST_UC = 1;
  localparam logic [7:0] SK_INIT_STATUS = 8'h00;
  // Sense byte 1 bit positions
  localparam int SK_S1_EOC = 5;
  localparam int SK_S1_NRF = 3;
  // Index count that ends a single-track search
  localparam logic [1:0] SK_IDX_LIMIT = 2'h2;
  // Running comparison verdicts
  typedef enum logic [1:0] {
    SK_REL_EQ = 2'b00,
    SK_REL_HI = 2'b01,
    SK_REL_LO = 2'b10
  } sk_rel_t;
  // Search conditions
  typedef enum logic [1:0] {
    SK_MODE_EQ = 2'b00,
    SK_MODE_HI = 2'b01,
    SK_MODE_EH = 2'b10
  } sk_mode_t;
  // Controller states
  typedef enum logic [2:0] {
    SK_IDLE = 3'b000,
    SK_INIT = 3'b001,
    SK_WAIT_KEY = 3'b010,
    SK_COMPARE = 3'b011,
    SK_WAIT_ECC = 3'b100,
    SK_DONE = 3'b101,
    SK_SR_MUX = 3'b110,
    SK_SR_ASM = 3'b111
  } sk_state_t;
endpackage

// File: rtl/sk_cmp.sv
// Key byte comparator, unsigned, first differing byte decides
`timescale 1ns/100ps
module sk_cmp
  import sk_pkg::*;
(
  // Running verdict in
  input wire sk_rel_t rel_in,
  // Bytes to compare
  input wire logic [7:0] trk_byte,
  input wire logic [7:0] host_byte,
  // Verdict out
  output sk_rel_t rel_out
);
  // A settled verdict is kept, otherwise this byte decides
  always_comb begin
    rel_out = rel_in;
    if (rel_in == SK_REL_EQ) begin
      if (trk_byte > host_byte) rel_out = SK_REL_HI;
      else if (trk_byte < host_byte) rel_out = SK_REL_LO;
    end
  end
endmodule // sk_cmp

// File: rtl/sk_buf.sv
// Two-entry buffer for channel bytes with parity flag
`timescale 1ns/100ps
module sk_buf
  import sk_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic clr,
  // Fill side
  input wire logic in_valid,
  input wire logic [8:0] in_data,
  output logic in_ready,
  // Drain side
  output logic out_valid,
  output logic [8:0] out_data,
  input wire logic out_ready
);
  typedef struct packed {
    logic [1:0][8:0] mem;
    logic rd;
    logic [1:0] cnt;
  } sk_buf_t;
  sk_buf_t b_reg, b_next;
  logic push, pop;
  // Handshakes from occupancy
  assign in_ready = (b_reg.cnt != 2'h2);
  assign out_valid = (b_reg.cnt != 2'h0);
  assign out_data = b_reg.mem[b_reg.rd];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;
  // Next buffer contents
  always_comb begin
    b_next = b_reg;
    if (push) b_next.mem[b_reg.rd ^ b_reg.cnt[0]] = in_data;
    if (pop) b_next.rd = ~b_reg.rd;
    b_next.cnt = 2'(b_reg.cnt + {1'b0, push} - {1'b0, pop});
    if (clr) b_next = '0;
  end
  // State register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) b_reg <= '0;
    else b_reg <= b_next;
  end
endmodule // sk_buf

// File: rtl/sk_unit.sv
// Search key command unit: key compare, ending status, sense, resets
// How it works
// - 29 single, A9 multi-track key equal
// - 49 decodes as single-track key high
// - Compare channel key with next track key
// - Equal ends CE DE SM, else CE DE
// - Key high adds SM only if track greater
// - Equal-or-high adds SM when track not lower
// - Single track: second index gives UC, NRF
// - Multi-track steps head at each index short of end of cylinder
// - End of cylinder gives UC and EOC
// - Zero key length never sets SM
// - Long count ends after key area read
// - Short count ends after key ECC checked
// - Short count SM from shortened field result
// - Chained search compares same record's key
// - Skip record zero key unless ID-chained
// - Initial status byte is all zero
// - Selective reset muxes checks, then clears them
// - Operator, offline, IPL force system reset
// - Channel parity error ends with UC
`timescale 1ns/100ps
module sk_unit
  import sk_pkg::*;
(
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // System reset sources
  input wire logic operator_reset_lamp_switch,
  input wire logic channel_offline,
  input wire logic ipl_load,
  // Command from channel
  input wire logic cmd_valid,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] cmd_count,
  input wire logic cmd_chained,
  input wire logic chain_from_id,
  output logic cmd_ready,
  // Key bytes from channel
  input wire logic ch_valid,
  input wire logic [7:0] ch_byte,
  input wire logic ch_parity_err,
  output logic ch_ready,
  // Status to channel
  output logic st_valid,
  output logic [7:0] st_byte,
  input wire logic st_ready,
  // Track side
  input wire logic trk_index,
  input wire logic trk_end_of_cyl,
  input wire logic trk_key_start,
  input wire logic trk_rec_zero,
  input wire logic [7:0] key_field_length,
  input wire logic trk_key_valid,
  input wire logic [7:0] trk_key_byte,
  input wire logic trk_ecc_done,
  output logic head_step,
  // Selective reset and checks
  input wire logic sel_reset,
  input wire logic [7:0] check1_set,
  input wire logic check2_set,
  output logic machine_fault_multiplex,
  output logic [7:0] machine_fault_register,
  output logic [7:0] sense_byte0,
  output logic [7:0] sense_byte1
);
  ////////////////////////////////////////////////////////////////////////////
  typedef struct packed {
    sk_state_t st;
    sk_mode_t mode;
    logic multi;
    logic chain_id;
    logic [15:0] cnt;
    logic [7:0] kleft;
    logic short_cnt;
    logic zero_kl;
    sk_rel_t rel;
    logic [1:0] idx;
    logic [7:0] stat;
    logic [7:0] sense0;
    logic [7:0] sense1;
    logic [7:0] chk1;
    logic chk2;
    logic [7:0] mfr;
    logic mfm;
    logic step;
  } sk_regs_t;
  sk_regs_t r_reg, r_next;
  logic sreset, bv, take;
  logic [8:0] bd;
  sk_rel_t rel_new;
  // Search condition met for a verdict
  function automatic logic sat(input sk_mode_t m, input sk_rel_t rl);
    case (m)
      SK_MODE_EQ: sat = (rl == SK_REL_EQ);
      SK_MODE_HI: sat = (rl == SK_REL_HI);
      SK_MODE_EH: sat = (rl != SK_REL_LO);
      default: sat = 1'b0;
    endcase
  endfunction
  // Ending status byte
  function automatic logic [7:0] ends(input logic sm, input logic uc);
    logic [7:0] s;
    s = 8'h00;
    s[SK_ST_CE] = 1'b1;
    s[SK_ST_DE] = 1'b1;
    s[SK_ST_SM] = sm;
    s[SK_ST_UC] = uc;
    ends = s;
  endfunction
  ////////////////////////////////////////////////////////////////////////////
  // Any of these forces the whole unit back to reset
  assign sreset = operator_reset_lamp_switch | channel_offline | ipl_load;
  // Channel key bytes pass through a two-entry buffer
  sk_buf u_buf (
    .clock(clock),
    .rst_b(rst_b),
    .clr(sreset),
    .in_valid(ch_valid),
    .in_data({ch_parity_err, ch_byte}),
    .in_ready(ch_ready),
    .out_valid(bv),
    .out_data(bd),
    .out_ready(take)
  );
  // Byte comparator
  sk_cmp u_cmp (
    .rel_in(r_reg.rel),
    .trk_byte(trk_key_byte),
    .host_byte(bd[7:0]),
    .rel_out(rel_new)
  );
  // Pop a channel byte only while count remains
  assign take = (r_reg.st == SK_COMPARE) && trk_key_valid && (r_reg.cnt != 16'h0000);
  // Outputs from state
  assign cmd_ready = (r_reg.st == SK_IDLE);
  assign st_valid = (r_reg.st == SK_INIT) || (r_reg.st == SK_DONE);
  assign st_byte = r_reg.stat;
  assign head_step = r_reg.step;
  assign machine_fault_multiplex = r_reg.mfm;
  assign machine_fault_register = r_reg.mfr;
  assign sense_byte0 = r_reg.sense0;
  assign sense_byte1 = r_reg.sense1;
  ////////////////////////////////////////////////////////////////////////////
  // Next state
  always_comb begin
    r_next = r_reg;
    r_next.step = 1'b0;
    // Check latches: a new event wins over a clear
    r_next.chk1 = r_reg.chk1 | check1_set;
    r_next.chk2 = r_reg.chk2 | check2_set;
    case (r_reg.st)
      SK_IDLE: begin
        if (cmd_valid) begin
          r_next.cnt = cmd_count;
          r_next.rel = SK_REL_EQ;
          r_next.chain_id = chain_from_id;
          r_next.stat = SK_INIT_STATUS;
          r_next.st = SK_INIT;
          if (!cmd_chained) r_next.idx = 2'h0;
          case (cmd_code)
            SK_CMD_EQ_ST, SK_CMD_EQ_MT: r_next.mode = SK_MODE_EQ;
            SK_CMD_HI_ST: r_next.mode = SK_MODE_HI;
            SK_CMD_EH_ST, SK_CMD_EH_MT: r_next.mode = SK_MODE_EH;
            default: begin
              r_next.stat = ends(1'b0, 1'b1);
              r_next.st = SK_DONE;
            end
          endcase
          r_next.multi = cmd_code[7];
        end
      end
      SK_INIT: begin
        if (st_ready) r_next.st = SK_WAIT_KEY;
      end
      SK_WAIT_KEY: begin
        if (trk_index) begin
          if (r_reg.multi) begin
            if (trk_end_of_cyl) begin
              r_next.sense1[SK_S1_EOC] = 1'b1;
              r_next.stat = ends(1'b0, 1'b1);
              r_next.st = SK_DONE;
            end else begin
              r_next.step = 1'b1;
            end
          end else begin
            r_next.idx = 2'(r_reg.idx + 2'h1);
            if (2'(r_reg.idx + 2'h1) == SK_IDX_LIMIT) begin
              r_next.sense1[SK_S1_NRF] = 1'b1;
              r_next.stat = ends(1'b0, 1'b1);
              r_next.st = SK_DONE;
            end
          end
        end else if (trk_key_start && !(trk_rec_zero && !r_reg.chain_id)) begin
          // First key area reached is the chained record's own key
          r_next.chain_id = 1'b0;
          r_next.kleft = key_field_length;
          r_next.zero_kl = (key_field_length == 8'h00);
          r_next.short_cnt = (r_reg.cnt < {8'h00, key_field_length});
          if (key_field_length == 8'h00) begin
            r_next.stat = ends(1'b0, 1'b0);
            r_next.st = SK_DONE;
          end else begin
            r_next.st = SK_COMPARE;
          end
        end
      end
      SK_COMPARE: begin
        if (trk_key_valid) begin
          r_next.kleft = 8'(r_reg.kleft - 8'h01);
          if (r_reg.cnt != 16'h0000) begin
            r_next.cnt = 16'(r_reg.cnt - 16'h0001);
            r_next.rel = rel_new;
          end
          if (r_reg.cnt != 16'h0000 && (!bv || bd[8])) begin
            r_next.stat = ends(1'b0, 1'b1);
            r_next.st = SK_DONE;
          end else if (r_reg.kleft == 8'h01) begin
            if (r_reg.short_cnt) begin
              r_next.st = SK_WAIT_ECC;
            end else begin
              r_next.stat = ends(sat(r_reg.mode, r_next.rel), 1'b0);
              r_next.st = SK_DONE;
            end
          end
        end
      end
      SK_WAIT_ECC: begin
        if (trk_ecc_done) begin
          r_next.stat = ends(sat(r_reg.mode, r_reg.rel), 1'b0);
          r_next.st = SK_DONE;
        end
      end
      SK_DONE: begin
        if (st_ready) r_next.st = SK_IDLE;
      end
      SK_SR_MUX: begin
        r_next.mfr = r_reg.chk1;
        r_next.st = SK_SR_ASM;
      end
      SK_SR_ASM: begin
        r_next.sense0 = {r_reg.chk2, r_reg.mfr[6:0]};
        r_next.mfm = 1'b0;
        r_next.chk1 = check1_set;
        r_next.chk2 = check2_set;
        r_next.st = SK_IDLE;
      end
      default: r_next.st = SK_IDLE;
    endcase
    // Selective reset abandons the command and gathers checks
    if (sel_reset) begin
      r_next.mfm = 1'b1;
      r_next.st = SK_SR_MUX;
    end
    if (sreset) r_next = '0;
  end
  // State register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) r_reg <= '0;
    else r_reg <= r_next;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Checks on the controller
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  a_init_zero: assert property (r_reg.st == SK_INIT |-> st_byte == 8'h00)
    else $error("initial status not zero");
  a_eq_decode: assert property (cmd_ready && cmd_valid && cmd_code == SK_CMD_EQ_MT && !sreset && !sel_reset
    |=> r_reg.mode == SK_MODE_EQ && r_reg.multi && r_reg.st == SK_INIT) else $error("key equal decode wrong");
  a_hi_decode: assert property (cmd_ready && cmd_valid && cmd_code == SK_CMD_HI_ST && !sreset && !sel_reset
    |=> r_reg.mode == SK_MODE_HI && !r_reg.multi) else $error("key high decode wrong");
  a_nrf_status: assert property ($rose(sense_byte1[SK_S1_NRF]) |-> st_byte == 8'h0E && st_valid)
    else $error("no record found without unit check");
  a_eoc_status: assert property ($rose(sense_byte1[SK_S1_EOC]) |-> st_byte == 8'h0E && st_valid)
    else $error("end of cylinder without unit check");
  a_head_step: assert property (head_step |-> $past(trk_index) && $past(r_reg.multi))
    else $error("head step without index");
  a_zero_kl_sm: assert property (r_reg.st == SK_DONE && r_reg.zero_kl |-> !st_byte[SK_ST_SM])
    else $error("modifier with zero key length");
  a_parity_uc: assert property (take && bd[8] && !sreset && !sel_reset
    |=> r_reg.st == SK_DONE && st_byte == 8'h0E) else $error("parity error not ending with unit check");
  a_r0_skip: assert property (r_reg.st == SK_WAIT_KEY && trk_key_start && trk_rec_zero && !r_reg.chain_id
    && !trk_index && !sreset && !sel_reset |=> r_reg.st == SK_WAIT_KEY) else $error("record zero key compared");
  a_check_clear: assert property (r_reg.st == SK_SR_ASM && !sreset && !sel_reset && check1_set == 8'h00
    |=> r_reg.chk1 == 8'h00 && !machine_fault_multiplex) else $error("checks not cleared");
  a_sys_reset: assert property (sreset |=> r_reg.st == SK_IDLE && sense_byte1 == 8'h00)
    else $error("system reset ignored");
  c_sm_end: cover property (st_valid && st_byte[SK_ST_SM]);
  c_nrf: cover property ($rose(sense_byte1[SK_S1_NRF]));
  c_short: cover property (r_reg.st == SK_WAIT_ECC ##1 r_reg.st == SK_DONE);
  c_sel_reset: cover property (r_reg.st == SK_SR_ASM);
endmodule // sk_unit

// File: tb/sk_chan_model.sv
// Channel-side model feeding key bytes with a parity flag
`timescale 1ns/100ps
module sk_chan_model (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  input wire logic stall,
  // Byte stream
  input wire logic ch_ready,
  output logic ch_valid,
  output logic [7:0] ch_byte,
  output logic ch_parity_err
);
  logic [8:0] q[$];
  logic [8:0] last = 9'h000;

  // Queue one byte, bit 8 marks bad parity
  task push(input logic [8:0] v);
    q.push_back(v);
  endtask

  // Hold an offered byte until taken; idle lines show the inverse
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      ch_valid <= 1'b0;
      ch_byte <= 8'h00;
      ch_parity_err <= 1'b0;
    end else begin
      if (ch_valid && ch_ready) begin
        void'(q.pop_front());
      end
      if (!(ch_valid && !ch_ready)) begin
        if (q.size() > 0 && !stall) begin
          ch_valid <= 1'b1;
          {ch_parity_err, ch_byte} <= q[0];
          last <= q[0];
        end else begin
          ch_valid <= 1'b0;
          ch_byte <= ~last[7:0];
          ch_parity_err <= 1'b0;
        end
      end
    end
  end
endmodule // sk_chan_model

// File: tb/search_key_command_unit_tb_top.sv
// Self-checking bench for the search key command unit
`timescale 1ns/100ps
module search_key_command_unit_tb_top;
  import sk_pkg::*;
  logic clock = 1'b0, rst_b = 1'b0, stall = 1'b0;
  logic operator_reset_lamp_switch = 0, channel_offline = 0, ipl_load = 0;
  logic cmd_valid = 0, cmd_chained = 0, chain_from_id = 0, cmd_ready;
  logic [7:0] cmd_code = 8'h00;
  logic [15:0] cmd_count = 16'h0000;
  logic ch_valid, ch_parity_err, ch_ready, st_valid, st_ready = 1'b1;
  logic [7:0] ch_byte, st_byte, key_field_length = 8'h00, trk_key_byte = 8'h00;
  logic trk_index = 0, trk_end_of_cyl = 0, trk_key_start = 0, trk_rec_zero = 0;
  logic trk_key_valid = 0, trk_ecc_done = 0, head_step, sel_reset = 0, check2_set = 0;
  logic [7:0] check1_set = 8'h00, machine_fault_register, sense_byte0, sense_byte1;
  logic machine_fault_multiplex;
  int num_errors = 0, compares = 0;

  // Clock
  always #10 clock = ~clock;

  sk_unit dut (.clock(clock), .rst_b(rst_b), .operator_reset_lamp_switch(operator_reset_lamp_switch),
    .channel_offline(channel_offline), .ipl_load(ipl_load), .cmd_valid(cmd_valid), .cmd_code(cmd_code),
    .cmd_count(cmd_count), .cmd_chained(cmd_chained), .chain_from_id(chain_from_id),
    .cmd_ready(cmd_ready), .ch_valid(ch_valid), .ch_byte(ch_byte), .ch_parity_err(ch_parity_err),
    .ch_ready(ch_ready), .st_valid(st_valid), .st_byte(st_byte), .st_ready(st_ready),
    .trk_index(trk_index), .trk_end_of_cyl(trk_end_of_cyl), .trk_key_start(trk_key_start),
    .trk_rec_zero(trk_rec_zero), .key_field_length(key_field_length), .trk_key_valid(trk_key_valid),
    .trk_key_byte(trk_key_byte), .trk_ecc_done(trk_ecc_done), .head_step(head_step),
    .sel_reset(sel_reset), .check1_set(check1_set), .check2_set(check2_set),
    .machine_fault_multiplex(machine_fault_multiplex), .machine_fault_register(machine_fault_register),
    .sense_byte0(sense_byte0), .sense_byte1(sense_byte1));

  sk_chan_model chan (.clock(clock), .rst_b(rst_b), .stall(stall), .ch_ready(ch_ready),
    .ch_valid(ch_valid), .ch_byte(ch_byte), .ch_parity_err(ch_parity_err));

  ////////////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task wrap_up();
    $display("compares %0d num_errors %0d", compares, num_errors);
    if (num_errors == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task check(input logic ok, input string msg);
    compares++;
    if (ok !== 1'b1) begin
      num_errors++;
      $display("FAIL at %0t: %s", $time, msg);
    end
  endtask

  // Wait a bounded time for status and compare it
  task wait_st(input logic [7:0] exp);
    int n;
    n = 0;
    do begin
      @(negedge clock);
      n++;
    end while (!st_valid && n < 60);
    check(st_valid === 1'b1 && st_byte === exp, "ending or initial status");
  endtask

  // Give a command; known codes answer with initial status
  task issue(input logic [7:0] code, input logic [15:0] cnt, input logic fid, input logic init);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_code <= code;
    cmd_count <= cnt;
    cmd_chained <= fid;
    chain_from_id <= fid;
    // Look at ready away from the edge, then let the taking edge pass
    do @(negedge clock); while (!cmd_ready);
    @(posedge clock);
    cmd_valid <= 1'b0;
    if (init) begin
      wait_st(SK_INIT_STATUS);
      @(posedge clock);
    end
  endtask

  // Queue n channel bytes, most significant first
  task load(input int n, input logic [31:0] b, input logic par);
    @(negedge clock);
    for (int i = 0; i < n; i++) chan.push({par, b[31-8*i -: 8]});
  endtask

  // One key area passing the head
  task key(input logic [7:0] kl, input logic rz, input int n, input logic [31:0] b);
    @(posedge clock);
    trk_key_start <= 1'b1;
    key_field_length <= kl;
    trk_rec_zero <= rz;
    @(posedge clock);
    trk_key_start <= 1'b0;
    trk_rec_zero <= 1'b0;
    for (int i = 0; i < n; i++) begin
      trk_key_valid <= 1'b1;
      trk_key_byte <= b[31-8*i -: 8];
      @(posedge clock);
      trk_key_valid <= 1'b0;
      // Return on the edge that takes the last byte, so one-cycle status is still seen
      if (i < n - 1) @(posedge clock);
    end
  endtask

  // Index pulse; head step expected on the following cycle or not
  task idx(input logic eoc, input logic hs);
    @(posedge clock);
    trk_index <= 1'b1;
    trk_end_of_cyl <= eoc;
    @(posedge clock);
    trk_index <= 1'b0;
    trk_end_of_cyl <= 1'b0;
    @(negedge clock);
    check(head_step === hs, "head step");
  endtask

  task nrf();
    issue(SK_CMD_EQ_ST, 16'h0002, 1'b0, 1'b1);
    idx(1'b0, 1'b0);
    idx(1'b0, 1'b0);
    // Status stands in the cycle whose middle idx has just checked
    check(st_valid === 1'b1 && st_byte === 8'h0E, "no record found status");
    check(sense_byte1[SK_S1_NRF] === 1'b1, "no record found");
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Scenarios
  task t_codes();
    logic [7:0] codes [5];
    logic [15:0] trk;
    logic sm;
    codes = '{SK_CMD_EQ_ST, SK_CMD_EQ_MT, SK_CMD_HI_ST, SK_CMD_EH_ST, SK_CMD_EH_MT};
    for (int c = 0; c < 5; c++) begin
      for (int r = 0; r < 3; r++) begin
        trk = (r == 0) ? 16'h8005 : (r == 1) ? 16'h8100 : 16'h7FFF;
        sm = (c < 2) ? (r == 0) : (c == 2) ? (r == 1) : (r != 2);
        issue(codes[c], 16'h0002, 1'b0, 1'b1);
        load(2, 32'h8005_0000, 1'b0);
        key(8'h02, 1'b0, 2, {trk, 16'h0000});
        wait_st(sm ? 8'h4C : 8'h0C);
      end
    end
    issue(8'h06, 16'h0002, 1'b0, 1'b0);
    wait_st(8'h0E);
  endtask

  task t_rec_zero();
    issue(SK_CMD_EQ_ST, 16'h0002, 1'b0, 1'b1);
    load(2, 32'h8005_0000, 1'b0);
    key(8'h02, 1'b1, 2, 32'h1111_0000);
    key(8'h02, 1'b0, 2, 32'h8005_0000);
    wait_st(8'h4C);
    issue(SK_CMD_EQ_ST, 16'h0002, 1'b1, 1'b1);
    load(2, 32'h8005_0000, 1'b0);
    key(8'h02, 1'b1, 2, 32'h1111_0000);
    wait_st(8'h0C);
  endtask

  task t_counts();
    issue(SK_CMD_EQ_ST, 16'h0001, 1'b0, 1'b1);
    load(1, 32'h8000_0000, 1'b0);
    key(8'h02, 1'b0, 2, 32'h80FF_0000);
    @(negedge clock);
    check(st_valid === 1'b0, "status before check bytes");
    @(posedge clock);
    trk_ecc_done <= 1'b1;
    @(posedge clock);
    trk_ecc_done <= 1'b0;
    wait_st(8'h4C);
    issue(SK_CMD_EQ_ST, 16'h0005, 1'b0, 1'b1);
    load(2, 32'h8005_0000, 1'b0);
    key(8'h02, 1'b0, 2, 32'h8005_0000);
    wait_st(8'h4C);
    issue(SK_CMD_HI_ST, 16'h0002, 1'b0, 1'b1);
    key(8'h00, 1'b0, 0, 32'h0000_0000);
    wait_st(8'h0C);
    issue(SK_CMD_EQ_ST, 16'h0001, 1'b0, 1'b1);
    load(1, 32'h8000_0000, 1'b1);
    key(8'h01, 1'b0, 1, 32'h8000_0000);
    wait_st(8'h0E);
  endtask

  task t_tracks();
    nrf();
    issue(SK_CMD_EQ_MT, 16'h0002, 1'b0, 1'b1);
    idx(1'b0, 1'b1);
    idx(1'b1, 1'b0);
    check(st_valid === 1'b1 && st_byte === 8'h0E, "end of cylinder status");
    check(sense_byte1[SK_S1_EOC] === 1'b1, "end of cylinder");
  endtask

  // Fill the buffer to refusal, hold status back, then drain
  task t_buffer();
    issue(SK_CMD_EH_ST, 16'h0003, 1'b0, 1'b1);
    stall <= 1'b1;
    load(3, 32'h0102_0300, 1'b0);
    repeat (3) @(negedge clock);
    check(ch_ready === 1'b1, "buffer took nothing");
    stall <= 1'b0;
    repeat (4) @(negedge clock);
    check(ch_ready === 1'b0 && ch_valid === 1'b1, "buffer full");
    st_ready <= 1'b0;
    key(8'h03, 1'b0, 3, 32'h0102_0300);
    wait_st(8'h4C);
    repeat (3) @(negedge clock);
    check(st_valid === 1'b1 && st_byte === 8'h4C, "status stands");
    check(ch_valid === 1'b0, "buffer drained");
    @(posedge clock);
    st_ready <= 1'b1;
  endtask

  task sel_rst(input logic [7:0] mfr, input logic [7:0] s0);
    @(posedge clock);
    sel_reset <= 1'b1;
    @(posedge clock);
    sel_reset <= 1'b0;
    @(negedge clock);
    check(machine_fault_multiplex === 1'b1, "multiplex set");
    @(negedge clock);
    check(machine_fault_register === mfr, "fault register");
    @(negedge clock);
    check(sense_byte0 === s0 && machine_fault_multiplex === 1'b0, "sense assembled");
  endtask

  task t_resets();
    @(posedge clock);
    check1_set <= 8'h5A;
    check2_set <= 1'b1;
    @(posedge clock);
    check1_set <= 8'h00;
    check2_set <= 1'b0;
    sel_rst(8'h5A, 8'hDA);
    sel_rst(8'h00, 8'h00);
    for (int s = 0; s < 3; s++) begin
      nrf();
      @(posedge clock);
      {operator_reset_lamp_switch, channel_offline, ipl_load} <= 3'h4 >> s;
      @(posedge clock);
      {operator_reset_lamp_switch, channel_offline, ipl_load} <= 3'h0;
      @(negedge clock);
      check(sense_byte1 === 8'h00 && cmd_ready === 1'b1, "system reset");
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence and watchdog
  initial begin
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    @(negedge clock);
    check(cmd_ready === 1'b1 && st_valid === 1'b0 && sense_byte1 === 8'h00, "reset values");
    t_codes();
    t_rec_zero();
    t_counts();
    t_tracks();
    t_buffer();
    t_resets();
    wrap_up();
  end

  initial begin
    #1_000_000;
    num_errors++;
    $display("FAIL at %0t: watchdog expired", $time);
    wrap_up();
  end
endmodule // search_key_command_unit_tb_top
